// ### dv/tcsr_far_end.sv
`timescale 1ns/1ns
// ==========================================================
// Far end: packet source and tape transport with set latency
module tcsr_far_end
  import tcsr_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [3:0] lat_i,
  input  wire logic       fetch_i,
  input  wire logic       go_i,
  input  wire logic       boot_i,
  output logic            start_o,
  output logic            done_o,
  output int              n_fetch_o,
  output int              n_go_o
);
  logic [3:0] s_cnt;
  logic [3:0] d_cnt;

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_o   <= 1'b0;
      done_o    <= 1'b0;
      s_cnt     <= 4'h0;
      d_cnt     <= 4'h0;
      n_fetch_o <= 0;
      n_go_o    <= 0;
    end else begin
      start_o <= 1'b0;
      done_o  <= 1'b0;
      if (fetch_i) begin
        s_cnt     <= lat_i;
        n_fetch_o <= n_fetch_o + 1;
      end else if (s_cnt != 4'h0) begin
        s_cnt   <= s_cnt - 4'h1;
        start_o <= (s_cnt == 4'h1);
      end
      if (go_i || boot_i) begin
        d_cnt <= lat_i;
      end else if (d_cnt != 4'h0) begin
        d_cnt  <= d_cnt - 4'h1;
        done_o <= (d_cnt == 4'h1);
      end
      if (go_i) begin
        n_go_o <= n_go_o + 1;
      end
    end
  end
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ns
module testbench
  import tcsr_pkg::*;
;
  logic        clk, rst_b, bus_init, stat_wr, cmd_ptr_wr, get_status, buf_def;
  logic        online, wp, lp, tape_end_marker, start, done;
  logic [15:0] wr_data, resid;
  logic [6:0]  att, ev;
  logic [3:0]  lat;
  logic [15:0] status, extended_status_zero, m_resid;
  logic [17:0] boot_addr;
  logic        fetch, go, bskip, bread, msg;
  int          n_fetch, n_go;
  int          n_msg = 0, n_skip = 0, n_read = 0, error_cnt = 0, n_checks = 0;

  tcsr_status uut (.core_clk_i(clk), .rst_b_i(rst_b), .bus_init_i(bus_init),
    .stat_wr_i(stat_wr), .stat_wr_data_i(wr_data), .cmd_ptr_wr_i(cmd_ptr_wr),
    .cmd_start_i(start), .cmd_bad_code_i(att[6]), .cmd_bad_addr_i(att[5]),
    .cmd_motion_i(att[4]), .cmd_reverse_i(att[3]), .cmd_write_i(att[2]),
    .cmd_clear_vol_i(att[1]), .cmd_counts_i(att[0]), .cmd_done_i(done),
    .ev_tape_mark_i(ev[6]), .ev_short_i(ev[5]), .ev_log_end_i(ev[4]), .ev_long_i(ev[3]),
    .ev_parity_i(ev[2]), .ev_lock_sw_i(ev[1]), .ev_moved_i(ev[0]), .resid_i(resid),
    .get_status_i(get_status), .msg_buf_defined_i(buf_def), .online_i(online),
    .write_protect_status_i(wp), .load_point_i(lp), .tape_end_marker_i(tape_end_marker),
    .main_status_o(status), .fetch_o(fetch), .motion_go_o(go), .boot_skip_o(bskip),
    .boot_read_o(bread), .boot_addr_o(boot_addr), .msg_valid_o(msg),
    .msg_resid_o(m_resid), .msg_extended_status_zero_o(extended_status_zero));

  tcsr_far_end far (.core_clk_i(clk), .rst_b_i(rst_b), .lat_i(lat), .fetch_i(fetch),
    .go_i(go), .boot_i(bskip || bread), .start_o(start), .done_o(done),
    .n_fetch_o(n_fetch), .n_go_o(n_go));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    n_msg  <= n_msg + (msg === 1'b1);
    n_skip <= n_skip + (bskip === 1'b1);
    n_read <= n_read + (bread === 1'b1);
  end

  task results;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task check(input logic [17:0] s, input logic [17:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task limit(input int i);
    if (i > 60) begin
      error_cnt++;
      results();
    end
  endtask

  // ==========================================================
  // One command: attributes, events, load point/protect, class, extended_status_zero bits
  task automatic run(input logic [6:0] a, input logic [6:0] e, input logic [1:0] lw,
                     input logic [2:0] c, input logic [15:0] x, input logic r);
    int i;
    int f0;
    int g0;
    f0 = n_fetch;
    g0 = n_go;
    i = 0;
    att <= a;
    ev <= e;
    lp <= lw[1];
    wp <= lw[0];
    lat <= lat ^ 4'h4;
    cmd_ptr_wr <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    cmd_ptr_wr <= 1'b0;
    #1 check(status[SR_RDY], 1'b0);
    while (msg !== 1'b1) begin
      @(posedge clk);
      #1 i = i + 1;
      limit(i);
    end
    check(extended_status_zero & 16'hFF80, x);
    check(extended_status_zero[X0_ONL], online);
    check(m_resid, (a[0] && !r) ? 16'h0012 : 16'h0000);
    @(posedge clk);
    #1 check(status & 16'h808E, {c != 3'h0, 7'h00, 1'b1, 3'h0, c, 1'b0});
    if (c == 3'h7)
      check(status[SR_SIP], 1'b1);
    check(n_go, r ? g0 : g0 + 1);
    check(n_fetch, f0 + 1);
    @(posedge clk);
  endtask

  task sw(input logic [15:0] d);
    stat_wr <= 1'b1;
    wr_data <= d;
    @(posedge clk);
    stat_wr <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial begin
    int i;
    int f0;
    int m0;
    {rst_b, bus_init, stat_wr, cmd_ptr_wr, get_status, wp, lp, tape_end_marker} = 8'h00;
    {buf_def, online} = 2'h3;
    wr_data = 16'h0000;
    resid = 16'h0012;
    att = 7'h00;
    ev = 7'h00;
    lat = 4'h1;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 check(status & 16'h00C0, 16'h0080);
    @(posedge clk);
    run(7'h10, 7'h00, 2'h0, 3'h3, 16'h0400, 1'b1);
    check(extended_status_zero[X0_VCK], 1'b1);
    run(7'h13, 7'h01, 2'h0, 3'h0, 16'h0080, 1'b0);
    run(7'h10, 7'h41, 2'h0, 3'h2, 16'h8080, 1'b0);
    run(7'h10, 7'h21, 2'h0, 3'h2, 16'h4080, 1'b0);
    run(7'h10, 7'h11, 2'h0, 3'h2, 16'h2080, 1'b0);
    run(7'h10, 7'h09, 2'h0, 3'h2, 16'h1080, 1'b0);
    run(7'h10, 7'h05, 2'h0, 3'h7, 16'h0080, 1'b0);
    run(7'h14, 7'h03, 2'h0, 3'h6, 16'h0880, 1'b0);
    run(7'h14, 7'h00, 2'h1, 3'h3, 16'h0C00, 1'b1);
    run(7'h18, 7'h00, 2'h2, 3'h3, 16'h0400, 1'b1);
    run(7'h50, 7'h00, 2'h0, 3'h3, 16'h0200, 1'b1);
    run(7'h30, 7'h00, 2'h0, 3'h3, 16'h0100, 1'b1);
    online <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check(status[SR_OFL], 1'b1);
    @(posedge clk);
    run(7'h12, 7'h00, 2'h0, 3'h3, 16'h0400, 1'b1);
    check(extended_status_zero[X0_VCK], 1'b1);
    check(extended_status_zero[X0_PED], PED_VALUE);
    online <= 1'b1;
    // Status request with and without a message buffer
    m0 = n_msg;
    buf_def <= 1'b0;
    get_status <= 1'b1;
    @(posedge clk);
    get_status <= 1'b0;
    repeat (6) @(posedge clk);
    #1 check(n_msg - m0, 0);
    @(posedge clk);
    buf_def <= 1'b1;
    get_status <= 1'b1;
    @(posedge clk);
    get_status <= 1'b0;
    repeat (6) @(posedge clk);
    #1 check(n_msg - m0, 1);
    // Bootstrap after bus init
    @(posedge clk);
    bus_init <= 1'b1;
    @(posedge clk);
    bus_init <= 1'b0;
    repeat (3) @(posedge clk);
    f0 = n_fetch;
    m0 = n_msg;
    sw(BOOT_WORD);
    sw(16'h0001);
    sw(BOOT_WORD);
    repeat (4) @(posedge clk);
    #1 check(n_skip, 0);
    @(posedge clk);
    sw(BOOT_WORD);
    i = 0;
    while (n_read == 0 || status[SR_RDY] !== 1'b1) begin
      @(posedge clk);
      #1 i = i + 1;
      limit(i);
    end
    check(n_skip, 1);
    check(n_read, 1);
    check(boot_addr, BOOT_ADDR);
    check(n_fetch, f0);
    check(n_msg, m0);
    @(posedge clk);
    sw(BOOT_WORD);
    sw(BOOT_WORD);
    repeat (6) @(posedge clk);
    #1 check(n_skip, 1);
    results();
  end
endmodule

// ### pkg/tcsr_pkg.sv
package tcsr_pkg;
  // ==========================================================
  // Main status bit positions
  localparam int SR_SC  = 15;
  localparam int SR_RDY = 7;
  localparam int SR_OFL = 6;
  localparam int SR_SIP = 5;
  localparam int SR_TCL = 1;
  localparam int SR_TCH = 3;
  // ==========================================================
  // Extended status zero bit positions
  localparam int X0_TMK = 15;
  localparam int X0_RLS = 14;
  localparam int X0_LET = 13;
  localparam int X0_RLL = 12;
  localparam int X0_WLE = 11;
  localparam int X0_NEF = 10;
  localparam int X0_ILC = 9;
  localparam int X0_ILA = 8;
  localparam int X0_MOT = 7;
  localparam int X0_ONL = 6;
  localparam int X0_VCK = 4;
  localparam int X0_PED = 3;
  localparam int X0_WLK = 2;
  localparam int X0_BOT = 1;
  localparam int X0_EOT = 0;
  // ==========================================================
  // Constants
  localparam logic [15:0] BOOT_WORD  = 16'h8001;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;
  localparam logic [17:0] BOOT_ADDR  = 18'h00000;
  localparam logic        PED_VALUE  = 1'b1;
  // ==========================================================
  // Termination classes
  typedef enum logic [2:0] {
    TCSR_TC_NORMAL = 3'b000,
    TCSR_TC_ATTN   = 3'b001,
    TCSR_TC_ALERT  = 3'b010,
    TCSR_TC_REJECT = 3'b011,
    TCSR_TC_REC1   = 3'b100,
    TCSR_TC_REC0   = 3'b101,
    TCSR_TC_LOST   = 3'b110,
    TCSR_TC_FATAL  = 3'b111
  } tcsr_tc_t;
  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    TCSR_IDLE  = 3'b000,
    TCSR_FETCH = 3'b001,
    TCSR_RUN   = 3'b010,
    TCSR_BSKIP = 3'b011,
    TCSR_BREAD = 3'b100
  } tcsr_state_t;
endpackage

// ### verilog/tcsr_status.sv
`timescale 1ns/1ns
// Contract
// - Ready bit high only while idle and able to take a command pointer.
// - Off-line bit follows transport; no motion go issued while off-line, but bootstrap skip and read go out on-line or off-line.
// - Read data parity error sets silo parity bit and class seven.
// - Class field sits in status bits three to one, valid with special condition.
// - Class codes zero to seven encoded as the documented table.
// - Two writes of octal 100001 after init: skip record, read second to zero.
// - Bootstrap never fetches a command packet.
// - Residual and extended status only go out in the message packet.
// - Residual count kept for read, space and skip commands only.
// - Tape mark seen sets its bit and class two.
// - Short record, early mark or load point sets short bit, class two.
// - Logical end only in enabled skip commands, class two.
// - Record longer than byte count sets long bit, class two.
// - Write protect error: class three without ring, six on lock switch.
// - Not executable, class three: reverse at load point, volume check, protected write.
// - Unsupported function or mode code sets bad code bit, class three.
// - Address wider than 18 bits or overflow sets bad address, class three.
// - Capstan moved bit set when tape moved in last operation.
// - Special condition set when last command ended with error or exception.
// - Unit available bit shows transport on-line and operable.
// - Volume changed set on on-line change and after every initialization.
module tcsr_status
  import tcsr_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        bus_init_i,
  input  wire logic        stat_wr_i,
  input  wire logic [15:0] stat_wr_data_i,
  input  wire logic        cmd_ptr_wr_i,
  input  wire logic        cmd_start_i,
  input  wire logic        cmd_bad_code_i,
  input  wire logic        cmd_bad_addr_i,
  input  wire logic        cmd_motion_i,
  input  wire logic        cmd_reverse_i,
  input  wire logic        cmd_write_i,
  input  wire logic        cmd_clear_vol_i,
  input  wire logic        cmd_counts_i,
  input  wire logic        cmd_done_i,
  input  wire logic        ev_tape_mark_i,
  input  wire logic        ev_short_i,
  input  wire logic        ev_log_end_i,
  input  wire logic        ev_long_i,
  input  wire logic        ev_parity_i,
  input  wire logic        ev_lock_sw_i,
  input  wire logic        ev_moved_i,
  input  wire logic [15:0] resid_i,
  input  wire logic        get_status_i,
  input  wire logic        msg_buf_defined_i,
  input  wire logic        online_i,
  input  wire logic        write_protect_status_i,
  input  wire logic        load_point_i,
  input  wire logic        tape_end_marker_i,
  output logic      [15:0] main_status_o,
  output logic             fetch_o,
  output logic             motion_go_o,
  output logic             boot_skip_o,
  output logic             boot_read_o,
  output logic      [17:0] boot_addr_o,
  output logic             msg_valid_o,
  output logic      [15:0] msg_resid_o,
  output logic      [15:0] msg_extended_status_zero_o
);
  // ==========================================================
  // State
  tcsr_state_t state, next_state;
  tcsr_tc_t    tcl, next_tcl;
  logic        sc, next_sc;
  logic        silo_parity_error, next_sip;
  logic        next_ofl;
  logic        onl_q, next_onl_q;
  logic        volume_changed, next_vck;
  logic        armed, next_armed;
  logic        boot_half, next_boot_half;
  logic [15:0] xflags, next_xflags;
  logic [15:0] resid, next_resid;
  logic        fetch, next_fetch;
  logic        go, next_go;
  logic        bskip, next_bskip;
  logic        bread, next_bread;
  logic        msg_v, next_msg_v;
  logic [15:0] msg_r, next_msg_r;
  logic [15:0] msg_x, next_msg_x;
  logic [15:0] extended_status_zero;
  logic [15:0] status_word;

  function automatic logic [15:0] bitv(input int pos);
    bitv = 16'h0001 << pos;
  endfunction

  // ==========================================================
  // Live extended status zero
  always_comb begin
    extended_status_zero = xflags;
    extended_status_zero[X0_ONL] = onl_q;
    extended_status_zero[X0_VCK] = volume_changed;
    extended_status_zero[X0_PED] = PED_VALUE;
    extended_status_zero[X0_WLK] = write_protect_status_i;
    extended_status_zero[X0_BOT] = load_point_i;
    extended_status_zero[X0_EOT] = tape_end_marker_i;
  end

  // ==========================================================
  // Status word and sequencing
  always_comb begin
    logic          reject;
    logic [15:0]   f;
    tcsr_tc_t      c;
    reject = 1'b0;
    f = WORD_ZERO;
    c = TCSR_TC_NORMAL;
    next_state = state;
    next_tcl = tcl;
    next_sc = sc;
    next_sip = silo_parity_error;
    next_ofl = ~online_i;
    next_onl_q = online_i;
    next_vck = volume_changed | (online_i != onl_q);
    next_armed = armed;
    next_boot_half = boot_half;
    next_xflags = xflags;
    next_resid = resid;
    next_fetch = 1'b0;
    next_go = 1'b0;
    next_bskip = 1'b0;
    next_bread = 1'b0;
    next_msg_v = 1'b0;
    next_msg_r = msg_r;
    next_msg_x = msg_x;
    case (state)
      TCSR_IDLE: begin
        if (cmd_ptr_wr_i) begin
          next_state = TCSR_FETCH;
          next_fetch = 1'b1;
          next_sc = 1'b0;
          next_sip = 1'b0;
          next_tcl = TCSR_TC_NORMAL;
        end else if (get_status_i && msg_buf_defined_i) begin
          next_msg_v = 1'b1;
          next_msg_r = resid;
          next_msg_x = extended_status_zero;
        end
      end
      TCSR_FETCH: begin
        if (cmd_start_i) begin
          if (cmd_bad_code_i) begin
            f = f | bitv(X0_ILC);
            reject = 1'b1;
          end
          if (cmd_bad_addr_i) begin
            f = f | bitv(X0_ILA);
            reject = 1'b1;
          end
          if (cmd_motion_i && !online_i) begin
            f = f | bitv(X0_NEF);
            reject = 1'b1;
          end
          if (cmd_reverse_i && load_point_i) begin
            f = f | bitv(X0_NEF);
            reject = 1'b1;
          end
          if (cmd_motion_i && volume_changed && !cmd_clear_vol_i) begin
            f = f | bitv(X0_NEF);
            reject = 1'b1;
          end
          if (cmd_write_i && write_protect_status_i) begin
            f = f | bitv(X0_NEF) | bitv(X0_WLE);
            reject = 1'b1;
          end
          if (cmd_clear_vol_i && !reject) begin
            next_vck = online_i != onl_q;
          end
          next_xflags = f;
          if (reject) begin
            next_state = TCSR_IDLE;
            next_tcl = TCSR_TC_REJECT;
            next_sc = 1'b1;
            if (msg_buf_defined_i) begin
              next_msg_v = 1'b1;
              next_msg_r = resid;
              next_msg_x = f | (extended_status_zero & ~xflags);
            end
          end else begin
            next_state = TCSR_RUN;
            next_go = cmd_motion_i;
          end
        end
      end
      TCSR_RUN, TCSR_BSKIP, TCSR_BREAD: begin
        if (cmd_done_i) begin
          f = xflags & (bitv(X0_ILC) | bitv(X0_ILA) | bitv(X0_NEF));
          if (ev_tape_mark_i) begin
            f = f | bitv(X0_TMK);
            c = TCSR_TC_ALERT;
          end
          if (ev_short_i) begin
            f = f | bitv(X0_RLS);
            c = TCSR_TC_ALERT;
          end
          if (ev_log_end_i) begin
            f = f | bitv(X0_LET);
            c = TCSR_TC_ALERT;
          end
          if (ev_long_i) begin
            f = f | bitv(X0_RLL);
            c = TCSR_TC_ALERT;
          end
          if (ev_lock_sw_i) begin
            f = f | bitv(X0_WLE);
            c = TCSR_TC_LOST;
          end
          if (ev_parity_i) begin
            next_sip = 1'b1;
            c = TCSR_TC_FATAL;
          end
          if (ev_moved_i) begin
            f = f | bitv(X0_MOT);
          end
          next_xflags = f;
          next_resid = cmd_counts_i ? resid_i : WORD_ZERO;
          next_tcl = c;
          next_sc = (c != TCSR_TC_NORMAL);
          if (state == TCSR_BSKIP) begin
            next_state = TCSR_BREAD;
            next_bread = 1'b1;
          end else begin
            next_state = TCSR_IDLE;
          end
          if (msg_buf_defined_i && state == TCSR_RUN) begin
            next_msg_v = 1'b1;
            next_msg_r = cmd_counts_i ? resid_i : WORD_ZERO;
            next_msg_x = f | (extended_status_zero & ~xflags & ~bitv(X0_MOT));
          end
        end
      end
      default: begin
        next_state = TCSR_IDLE;
      end
    endcase
    if (bus_init_i) begin
      next_armed = 1'b1;
      next_boot_half = 1'b0;
      next_vck = 1'b1;
    end
    if (stat_wr_i) begin
      next_state = TCSR_IDLE;
      next_tcl = TCSR_TC_NORMAL;
      next_sc = 1'b0;
      next_sip = 1'b0;
      next_xflags = WORD_ZERO;
      next_vck = 1'b1;
      next_go = 1'b0;
      next_fetch = 1'b0;
      next_bread = 1'b0;
      next_msg_v = 1'b0;
      next_boot_half = armed && stat_wr_data_i == BOOT_WORD && !boot_half;
      if (armed && boot_half && stat_wr_data_i == BOOT_WORD) begin
        next_state = TCSR_BSKIP;
        next_bskip = 1'b1;
        next_armed = 1'b0;
      end
    end
  end

  always_comb begin
    status_word = WORD_ZERO;
    status_word[SR_SC] = sc;
    status_word[SR_RDY] = (state == TCSR_IDLE);
    status_word[SR_OFL] = next_ofl;
    status_word[SR_SIP] = silo_parity_error;
    status_word[SR_TCH:SR_TCL] = tcl;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= TCSR_IDLE;
      tcl <= TCSR_TC_NORMAL;
      sc <= 1'b0;
      silo_parity_error <= 1'b0;
      onl_q <= 1'b0;
      volume_changed <= 1'b1;
      armed <= 1'b1;
      boot_half <= 1'b0;
      xflags <= WORD_ZERO;
      resid <= WORD_ZERO;
      fetch <= 1'b0;
      go <= 1'b0;
      bskip <= 1'b0;
      bread <= 1'b0;
      msg_v <= 1'b0;
      msg_r <= WORD_ZERO;
      msg_x <= WORD_ZERO;
      main_status_o <= WORD_ZERO;
    end else begin
      state <= next_state;
      tcl <= next_tcl;
      sc <= next_sc;
      silo_parity_error <= next_sip;
      onl_q <= next_onl_q;
      volume_changed <= next_vck;
      armed <= next_armed;
      boot_half <= next_boot_half;
      xflags <= next_xflags;
      resid <= next_resid;
      fetch <= next_fetch;
      go <= next_go;
      bskip <= next_bskip;
      bread <= next_bread;
      msg_v <= next_msg_v;
      msg_r <= next_msg_r;
      msg_x <= next_msg_x;
      main_status_o <= status_word;
    end
  end

  assign fetch_o = fetch;
  assign motion_go_o = go;
  assign boot_skip_o = bskip;
  assign boot_read_o = bread;
  assign boot_addr_o = BOOT_ADDR;
  assign msg_valid_o = msg_v;
  assign msg_resid_o = msg_r;
  assign msg_extended_status_zero_o = msg_x;

  // ==========================================================
  // Checks
  property p_ready_idle;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      main_status_o[SR_RDY] |-> $past(state) == TCSR_IDLE;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready while busy");

  property p_no_go_offline;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (state == TCSR_FETCH && cmd_start_i && !online_i) |=> !motion_go_o;
  endproperty
  a_no_go_offline: assert property (p_no_go_offline) else $error("motion off-line");

  property p_parity_fatal;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (state == TCSR_RUN && cmd_done_i && ev_parity_i && !stat_wr_i)
        |=> ##1 main_status_o[SR_SIP] && main_status_o[SR_TCH:SR_TCL] == TCSR_TC_FATAL;
  endproperty
  a_parity_fatal: assert property (p_parity_fatal) else $error("parity class");

  property p_sc_class;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      main_status_o[SR_SC] == (main_status_o[SR_TCH:SR_TCL] != TCSR_TC_NORMAL);
  endproperty
  a_sc_class: assert property (p_sc_class) else $error("special condition");

  property p_boot_seq;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      boot_skip_o |-> !fetch_o && boot_addr_o == BOOT_ADDR;
  endproperty
  a_boot_seq: assert property (p_boot_seq) else $error("boot fetched");

  property p_boot_read;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (state == TCSR_BSKIP && cmd_done_i && !stat_wr_i) |=> boot_read_o;
  endproperty
  a_boot_read: assert property (p_boot_read) else $error("boot read missing");

  property p_tmk_alert;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (state == TCSR_RUN && cmd_done_i && ev_tape_mark_i && !ev_parity_i
       && !ev_lock_sw_i && !stat_wr_i && msg_buf_defined_i)
        |=> msg_valid_o && msg_extended_status_zero_o[X0_TMK] ##1 main_status_o[SR_TCH:SR_TCL] == TCSR_TC_ALERT;
  endproperty
  a_tmk_alert: assert property (p_tmk_alert) else $error("tape mark class");

  property p_reject_class;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (state == TCSR_FETCH && cmd_start_i && cmd_bad_code_i && !stat_wr_i)
        |=> ##1 main_status_o[SR_TCH:SR_TCL] == TCSR_TC_REJECT && main_status_o[SR_RDY];
  endproperty
  a_reject_class: assert property (p_reject_class) else $error("reject class");

  property p_vck_init;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      stat_wr_i |=> volume_changed;
  endproperty
  a_vck_init: assert property (p_vck_init) else $error("volume flag");

  property p_msg_buf;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      msg_valid_o |-> $past(msg_buf_defined_i);
  endproperty
  a_msg_buf: assert property (p_msg_buf) else $error("message without buffer");
endmodule
